// File: ext_party.sv
// far side model: master clear driver and external clock source
// assumes the bench clock; the master clear pin has a pull-up
`timescale 1ns/1ns
module ext_party (
  input  wire logic clk,
  input  wire logic master_clear_n_low,
  input  wire logic osc_run,
  output logic      master_clear_n,
  output logic      osc_in_pin
);
  logic [1:0] div_ff = 2'h0;
  logic       osc_ff = 1'b0;
  // pull-up wins as soon as the driver lets go
  assign master_clear_n = !master_clear_n_low;
  assign osc_in_pin     = osc_ff;
  // six clk cycles a period, well below clk/2; stands still when stopped
  always @(posedge clk) begin
    if (osc_run) begin
      div_ff <= (div_ff == 2'h2) ? 2'h0 : div_ff + 2'h1;
      if (div_ff == 2'h2) osc_ff <= !osc_ff;
    end
  end
endmodule

// File: reset_seq.sv
// reset source combiner, cause flags and oscillator pin control
// assumes inputs synchronous to clk; osc_in_pin is sampled, so it must run below clk/2
// How it works
// - In external clock mode the output oscillator pin carries the input clock divided by four.
// - External clock modes skip the oscillator start-up delay after power-on and on wake.
// - Oscillator feedback is off in external clock modes and on in crystal modes.
// - The outside party holds master_clear_n low to request reset and the device stays in reset meanwhile.
// - Low pulses on master_clear_n shorter than the filter time are ignored.
// - The master clear pin is never driven by the device.
// - A rising power-on detector starts a power-on reset and start-up sequence.
// - The power-on flag is cleared by each power-on reset and set only by software.
// - Brown-out reset only works while the regulator enable pin is high.
// - A brown-out longer than the qualification time resets the device.
// - Brown-out reset lasts as long as the supply stays below threshold.
// - After brown-out the power-up timer holds reset for its full period and restarts on a new brown-out.
// - The brown-out flag is cleared on every power-on reset, and on a brown-out only while the regulator enable pin is high.
`timescale 1ns/1ns
module reset_seq
  import reset_seq_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         master_clear_n,
  input  wire logic         por_detect,
  input  wire logic         bor_below,
  input  wire logic         regulator_enable_pin,
  input  wire logic         wdt_timeout,
  input  wire logic         wake_req,
  input  wire osc_mode_e    osc_mode,
  input  wire logic         osc_in_pin,
  input  wire flag_write_s  flag_write,
  output logic              sys_rst,
  output logic              startup_busy,
  output cause_flags_s      reset_control_reg,
  output logic              osc_out_pin,
  output logic              osc_out_oe,
  output logic              osc_feedback_en,
  output logic              master_clear_out,
  output logic              master_clear_oe
);
  typedef struct packed {
    seq_e         seq;
    logic [11:0]  cnt;
    logic         ost_holds_rst;
    logic         por_prev;
    logic         bor_active;
    logic [1:0]   rel;
    logic         sys_rst;
    logic         busy;
    cause_flags_s flags;
    logic         osc_prev;
    logic [1:0]   div_cnt;
    logic         osc_out;
    logic         osc_oe;
    logic         fb_en;
    logic         master_clear_n_out;
    logic         master_clear_n_oe;
  } seq_state_s;

  seq_state_s st_ff;
  seq_state_s nxt_st;
  logic       master_clear_n_qual;
  logic       bor_qual;

  function automatic logic is_ext_clock(input osc_mode_e m);
    is_ext_clock = (m == EXTERNAL_CLOCK_MODE) || (m == EXTERNAL_CLOCK_MULTIPLIED_MODE);
  endfunction

  // master_clear_n low must persist before it counts
  level_qualifier #(
    .COUNT (MASTER_CLEAR_N_QUAL_CYCLES)
  ) u_master_clear_n_filter (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .active    (!master_clear_n),
    .qualified (master_clear_n_qual)
  );

  // brown-out detection gated by the regulator enable
  level_qualifier #(
    .COUNT (BOR_QUAL_CYCLES)
  ) u_bor_filter (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .active    (bor_below && regulator_enable_pin),
    .qualified (bor_qual)
  );

  always_comb begin
    logic por_event;
    logic bor_event;
    logic hold_req;
    por_event = 1'b0;
    bor_event = 1'b0;
    hold_req  = 1'b0;
    nxt_st    = st_ff;
    nxt_st.por_prev = por_detect;
    por_event = por_detect && !st_ff.por_prev;

    // sequencer
    if (!por_detect) begin
      nxt_st.seq = SEQ_POR_HOLD;
      nxt_st.cnt = 12'h000;
    end else if (por_event) begin
      nxt_st.cnt = 12'h000;
      if (is_ext_clock(osc_mode)) begin
        nxt_st.seq = SEQ_RUN;
      end else begin
        nxt_st.seq           = SEQ_OST;
        nxt_st.ost_holds_rst = 1'b1;
      end
    end else if (bor_qual) begin
      nxt_st.seq = SEQ_BOR_HOLD;
      nxt_st.cnt = 12'h000;
    end else begin
      unique case (st_ff.seq)
        SEQ_POR_HOLD: begin
          nxt_st.seq = SEQ_POR_HOLD;
        end
        SEQ_BOR_HOLD: begin
          nxt_st.seq = SEQ_PWRT;
        end
        SEQ_PWRT: begin
          if (st_ff.cnt == PWRT_CYCLES - 12'h001) begin
            nxt_st.seq = SEQ_RUN;
            nxt_st.cnt = 12'h000;
          end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
          end
        end
        SEQ_OST: begin
          if (st_ff.cnt == OST_CYCLES - 12'h001) begin
            nxt_st.seq           = SEQ_RUN;
            nxt_st.cnt           = 12'h000;
            nxt_st.ost_holds_rst = 1'b0;
          end else begin
            nxt_st.cnt = st_ff.cnt + 12'h001;
          end
        end
        SEQ_RUN: begin
          // wake from sleep waits for the crystal, the core is not reset
          if (wake_req && !is_ext_clock(osc_mode)) begin
            nxt_st.seq           = SEQ_OST;
            nxt_st.cnt           = 12'h000;
            nxt_st.ost_holds_rst = 1'b0;
          end
        end
        default: begin
          nxt_st.seq = SEQ_POR_HOLD;
        end
      endcase
    end

    bor_event = bor_qual && !st_ff.bor_active;
    nxt_st.bor_active = bor_qual;

    // cause flags: hardware clear wins over a same-cycle software set
    if (flag_write.por_set) begin
      nxt_st.flags.por_n = 1'b1;
    end
    if (flag_write.bor_set) begin
      nxt_st.flags.bor_n = 1'b1;
    end
    if (por_event) begin
      nxt_st.flags.por_n = 1'b0;
    end
    if (por_event || bor_event) begin
      nxt_st.flags.bor_n = 1'b0;
    end

    // merged reset: assert next edge, release through a short pipe
    hold_req = (st_ff.seq == SEQ_POR_HOLD) || (st_ff.seq == SEQ_BOR_HOLD) || (st_ff.seq == SEQ_PWRT)
             || ((st_ff.seq == SEQ_OST) && st_ff.ost_holds_rst)
             || master_clear_n_qual || wdt_timeout || !por_detect || bor_qual;
    if (hold_req) begin
      nxt_st.rel     = 2'h0;
      nxt_st.sys_rst = 1'b1;
    end else begin
      nxt_st.rel     = {st_ff.rel[0], 1'b1};
      nxt_st.sys_rst = !st_ff.rel[REL_STAGES-1];
    end
    nxt_st.busy = (nxt_st.seq != SEQ_RUN);

    // clock pin control
    nxt_st.osc_prev = osc_in_pin;
    if (osc_in_pin && !st_ff.osc_prev) begin
      nxt_st.div_cnt = st_ff.div_cnt + 2'h1;
    end
    nxt_st.osc_out = (osc_mode == EXTERNAL_CLOCK_MODE) && ((st_ff.div_cnt & OSC_DIV_MSB) != 2'h0);
    nxt_st.osc_oe  = (osc_mode == EXTERNAL_CLOCK_MODE);
    nxt_st.fb_en   = !is_ext_clock(osc_mode);

    // the master clear pin is input only
    nxt_st.master_clear_n_out = 1'b0;
    nxt_st.master_clear_n_oe  = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff               <= '0;
      st_ff.seq           <= SEQ_POR_HOLD;
      st_ff.sys_rst       <= 1'b1;
      st_ff.busy          <= 1'b1;
      st_ff.flags.por_n   <= FLAG_RESET_VAL;
      st_ff.flags.bor_n   <= FLAG_RESET_VAL;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign sys_rst           = st_ff.sys_rst;
  assign startup_busy      = st_ff.busy;
  assign reset_control_reg = st_ff.flags;
  assign osc_out_pin       = st_ff.osc_out;
  assign osc_out_oe        = st_ff.osc_oe;
  assign osc_feedback_en   = st_ff.fb_en;
  assign master_clear_out  = st_ff.master_clear_n_out;
  assign master_clear_oe   = st_ff.master_clear_n_oe;
endmodule

// File: reset_seq_asserts.sv
// port assertions for reset_seq
// assumes ce held high and one clock domain
`timescale 1ns/1ns
module reset_seq_asserts
  import reset_seq_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         master_clear_n,
  input wire logic         por_detect,
  input wire logic         bor_below,
  input wire logic         regulator_enable_pin,
  input wire logic         wdt_timeout,
  input wire osc_mode_e    osc_mode,
  input wire flag_write_s  flag_write,
  input wire logic         sys_rst,
  input wire cause_flags_s reset_control_reg,
  input wire logic         osc_out_pin,
  input wire logic         osc_out_oe,
  input wire logic         osc_feedback_en,
  input wire logic         master_clear_out,
  input wire logic         master_clear_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire bor_low = bor_below && regulator_enable_pin;
  wire ext     = osc_mode inside {EXTERNAL_CLOCK_MODE, EXTERNAL_CLOCK_MULTIPLIED_MODE};
  // 13 and 25 samples, split to keep repetitions short
  sequence master_clear_n_held;
    !master_clear_n [*8] ##1 !master_clear_n [*5];
  endsequence
  sequence bor_held;
    bor_low [*8] ##1 bor_low [*8] ##1 bor_low [*8] ##1 bor_low;
  endsequence
  a_pin_not_driven: assert property (!master_clear_oe && !master_clear_out)
    else $error("master clear pin driven");
  a_ext_no_feedback: assert property (ext && !$past(rst) |=> !osc_feedback_en)
    else $error("feedback on in external mode");
  a_xtal_feedback_on: assert property (!ext && !$past(rst) |=> osc_feedback_en)
    else $error("feedback off in crystal mode");
  a_div_out_on: assert property (osc_mode == EXTERNAL_CLOCK_MODE && !$past(rst) |=> osc_out_oe)
    else $error("clock output not enabled");
  a_div_out_idle: assert property (osc_mode != EXTERNAL_CLOCK_MODE && !$past(rst)
    |=> !osc_out_oe && !osc_out_pin)
    else $error("clock output active outside mode");
  a_por_clears_flags: assert property ($rose(por_detect) |=> reset_control_reg == 2'h0)
    else $error("flags not cleared by power-on");
  a_por_flag_sw: assert property ($rose(reset_control_reg.por_n) |-> $past(flag_write.por_set))
    else $error("power-on flag set by hardware");
  a_master_clear_n_resets: assert property (master_clear_n_held |-> ##[1:2] sys_rst)
    else $error("held master clear gave no reset");
  a_bor_resets: assert property (bor_held |-> ##[1:3] (sys_rst && !reset_control_reg.bor_n))
    else $error("brown-out gave no reset");
  a_wdt_resets: assert property (wdt_timeout |=> sys_rst)
    else $error("internal request gave no reset");
endmodule

bind reset_seq reset_seq_asserts u_chk (
  .clk                  (clk),
  .rst                  (rst),
  .master_clear_n       (master_clear_n),
  .por_detect           (por_detect),
  .bor_below            (bor_below),
  .regulator_enable_pin (regulator_enable_pin),
  .wdt_timeout          (wdt_timeout),
  .osc_mode             (osc_mode),
  .flag_write           (flag_write),
  .sys_rst              (sys_rst),
  .reset_control_reg    (reset_control_reg),
  .osc_out_pin          (osc_out_pin),
  .osc_out_oe           (osc_out_oe),
  .osc_feedback_en      (osc_feedback_en),
  .master_clear_out     (master_clear_out),
  .master_clear_oe      (master_clear_oe)
);

// File: reset_seq_pkg.sv
// shared constants and types for the reset sequencer, plus its input qualifier
// assumes one 125 MHz clock, synchronous active-high rst, all inputs synchronous
package reset_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 8;
  localparam int unsigned PWRT_TIME_NS     = 1000;
  localparam int unsigned BOR_QUALIFY_NS   = 200;
  localparam int unsigned MASTER_CLEAR_N_FILTER_NS   = 100;
  localparam int unsigned OST_TIME_NS      = 8192;
  localparam int unsigned CNT_W            = 12;
  // least times round up to whole cycles
  localparam logic [11:0] PWRT_CYCLES      = 12'((PWRT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] BOR_QUAL_CYCLES  = 12'((BOR_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] MASTER_CLEAR_N_QUAL_CYCLES = 12'((MASTER_CLEAR_N_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] OST_CYCLES       = 12'((OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  OSC_DIV_MSB      = 2'h2;
  localparam int unsigned REL_STAGES       = 2;
  localparam logic        FLAG_RESET_VAL   = 1'b0;

  typedef enum logic [1:0] {
    CRYSTAL_HIGH_SPEED_MODE,
    CRYSTAL_MULTIPLIED_MODE,
    EXTERNAL_CLOCK_MODE,
    EXTERNAL_CLOCK_MULTIPLIED_MODE
  } osc_mode_e;

  typedef enum logic [2:0] {
    SEQ_POR_HOLD,
    SEQ_BOR_HOLD,
    SEQ_PWRT,
    SEQ_OST,
    SEQ_RUN
  } seq_e;

  // software write-one strobes to the cause flags
  typedef struct packed {
    logic por_set;
    logic bor_set;
  } flag_write_s;

  // reset_control_reg bit 1 and bit 0, both active low
  typedef struct packed {
    logic por_n;
    logic bor_n;
  } cause_flags_s;

  typedef struct packed {
    logic [11:0] cnt;
    logic        qual;
  } qual_state_s;
endpackage

`timescale 1ns/1ns
module level_qualifier
  import reset_seq_pkg::*;
#(
  parameter logic [11:0] COUNT = 12'h001
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic active,
  output logic      qualified
);
  qual_state_s st_ff;
  qual_state_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!active) begin
      nxt_st.cnt  = 12'h000;
      nxt_st.qual = 1'b0;
    end else if (!st_ff.qual) begin
      if (st_ff.cnt == COUNT - 12'h001) begin
        nxt_st.qual = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign qualified = st_ff.qual;
endmodule

// File: testbench.sv
// self-checking bench for reset_seq
// assumes ext_party as far side and 125 MHz clk
`timescale 1ns/1ns
module testbench
  import reset_seq_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, por_detect = 1'b0, bor_below = 1'b0;
  logic regulator_enable_pin = 1'b0, wdt_timeout = 1'b0, wake_req = 1'b0;
  logic master_clear_n_low = 1'b0, osc_run = 1'b1, master_clear_n, osc_in_pin, p;
  osc_mode_e osc_mode = EXTERNAL_CLOCK_MODE;
  flag_write_s flag_write = 2'h0;
  logic sys_rst, startup_busy, osc_out_pin, osc_out_oe, osc_feedback_en, master_clear_out, master_clear_oe;
  cause_flags_s reset_control_reg;
  int n_fail = 0, samples_checked = 0, n;
  reset_seq dut (
    .clk                  (clk),
    .rst                  (rst),
    .ce                   (ce),
    .master_clear_n       (master_clear_n),
    .por_detect           (por_detect),
    .bor_below            (bor_below),
    .regulator_enable_pin (regulator_enable_pin),
    .wdt_timeout          (wdt_timeout),
    .wake_req             (wake_req),
    .osc_mode             (osc_mode),
    .osc_in_pin           (osc_in_pin),
    .flag_write           (flag_write),
    .sys_rst              (sys_rst),
    .startup_busy         (startup_busy),
    .reset_control_reg    (reset_control_reg),
    .osc_out_pin          (osc_out_pin),
    .osc_out_oe           (osc_out_oe),
    .osc_feedback_en      (osc_feedback_en),
    .master_clear_out     (master_clear_out),
    .master_clear_oe      (master_clear_oe)
  );
  ext_party u_far (.clk(clk), .master_clear_n_low(master_clear_n_low), .osc_run(osc_run),
    .master_clear_n(master_clear_n), .osc_in_pin(osc_in_pin));
  initial forever #4 clk = !clk;
  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      @(negedge clk);
      chk(sys_rst === 1'b0, "unexpected reset");
    end
  endtask
  // cycles until the merged reset lets go, bounded
  task automatic rel(output int c);
    c = 0;
    while (sys_rst !== 1'b0 && c < 2000) begin
      @(negedge clk);
      c++;
    end
  endtask
  initial begin
    cyc(20000);
    n_fail++;
    end_sim();
  end
  initial begin
    cyc(16);
    @(posedge clk) rst <= 1'b0;
    cyc(4);
    chk(sys_rst === 1'b1 && startup_busy === 1'b1, "ran before power-on");
    @(posedge clk) por_detect <= 1'b1;
    rel(n);
    // por edge, then two release stages: five samples with no start-up delay
    chk(n <= 5, "start delay in external mode");
    chk(reset_control_reg === 2'h0, "flags after power-on");
    chk(osc_out_oe === 1'b1 && osc_feedback_en === 1'b0, "ext clock pins");
    n = 0;
    p = osc_out_pin;
    repeat (240) begin
      @(negedge clk);
      n += int'(osc_out_pin !== p);
      p = osc_out_pin;
    end
    chk(n == 20, "divided clock rate");
    @(posedge clk) flag_write <= 2'h3;
    @(posedge clk) flag_write <= 2'h0;
    cyc(2);
    chk(reset_control_reg === 2'h3, "software flag set");
    @(posedge clk) master_clear_n_low <= 1'b1;
    repeat (12) @(posedge clk);
    master_clear_n_low <= 1'b0;
    quiet(20);
    @(posedge clk) master_clear_n_low <= 1'b1;
    cyc(30);
    chk(sys_rst === 1'b1, "no reset on held master clear");
    @(posedge clk) master_clear_n_low <= 1'b0;
    rel(n);
    chk(n <= 5 && reset_control_reg === 2'h3, "master clear release");
    @(posedge clk) wdt_timeout <= 1'b1;
    @(posedge clk) wdt_timeout <= 1'b0;
    cyc(1);
    chk(sys_rst === 1'b1 && master_clear_oe === 1'b0, "internal reset");
    rel(n);
    chk(n <= 3, "internal reset release");
    @(posedge clk) bor_below <= 1'b1;
    quiet(40);
    @(posedge clk) bor_below <= 1'b0;
    regulator_enable_pin <= 1'b1;
    @(posedge clk) bor_below <= 1'b1;
    cyc(50);
    chk(sys_rst === 1'b1 && reset_control_reg === 2'h2, "brown-out reset");
    @(posedge clk) bor_below <= 1'b0;
    cyc(60);
    chk(sys_rst === 1'b1, "power-up timer hold");
    @(posedge clk) bor_below <= 1'b1;
    cyc(30);
    @(posedge clk) bor_below <= 1'b0;
    rel(n);
    chk(n >= 125 && n <= 132, "power-up timer restart");
    @(posedge clk) osc_mode <= CRYSTAL_HIGH_SPEED_MODE;
    por_detect <= 1'b0;
    cyc(4);
    @(posedge clk) por_detect <= 1'b1;
    rel(n);
    chk(n >= 1024 && n <= 1032, "crystal start delay");
    chk(osc_feedback_en === 1'b1 && osc_out_oe === 1'b0, "crystal pins");
    chk(reset_control_reg === 2'h0, "flags after second power-on");
    // wake in crystal mode waits for the oscillator without resetting the core
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    cyc(1);
    chk(startup_busy === 1'b1 && sys_rst === 1'b0, "crystal wake start");
    quiet(1000);
    chk(startup_busy === 1'b1, "crystal wake delay too short");
    cyc(30);
    chk(startup_busy === 1'b0 && sys_rst === 1'b0, "crystal wake end");
    @(posedge clk) osc_mode <= EXTERNAL_CLOCK_MULTIPLIED_MODE;
    cyc(2);
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    cyc(1);
    chk(startup_busy === 1'b0 && sys_rst === 1'b0, "multiplied ext wake delay");
    chk(osc_feedback_en === 1'b0 && osc_out_oe === 1'b0 && osc_out_pin === 1'b0, "multiplied ext pins");
    @(posedge clk) osc_mode <= CRYSTAL_MULTIPLIED_MODE;
    cyc(2);
    chk(osc_feedback_en === 1'b1 && osc_out_oe === 1'b0 && osc_out_pin === 1'b0, "multiplied crystal pins");
    end_sim();
  end
endmodule
